/* logic/scg_pkg.sv */
// constants and types for the sleep-mode clock gating block
package scg_pkg;
   localparam int          SCG_NUM_PERIPH      = 9;
   localparam int          SCG_PADDR_W         = 12;
   localparam logic [31:0] SCG_SYSCTL_BASE     = 32'h400FE000;
   localparam logic [11:0] SCG_RUN_GATE_OFF    = 12'h104;
   localparam logic [11:0] SCG_SLEEP_GATE_OFF  = 12'h114;
   localparam logic [11:0] SCG_DEEP_GATE_OFF   = 12'h124;
   localparam logic [11:0] SCG_RUN_CFG_OFF     = 12'h060;
   localparam logic [11:0] SCG_POWER_STATE_OFF = 12'h200;
   localparam logic [31:0] SCG_GATE_RESET      = 32'h00000000;
   localparam logic [31:0] SCG_GATE_MASK       = 32'h07071013;
   localparam int          SCG_AUTO_GATE_BIT   = 11;
   localparam logic [31:0] SCG_RUN_CFG_MASK    = 32'h00000800;
   localparam logic [31:0] SCG_RUN_CFG_RESET   = 32'h00000000;
   localparam logic [1:0]  SCG_PSTATE_RUN      = 2'h0;
   localparam logic [1:0]  SCG_PSTATE_SLEEP    = 2'h1;
   localparam logic [1:0]  SCG_PSTATE_DEEP     = 2'h3;
   localparam logic [31:0] SCG_ZERO_WORD       = 32'h00000000;
   // register bit carrying each peripheral enable, index order of the status word
   localparam int SCG_BIT_ASYNC0 = 0;
   localparam int SCG_BIT_ASYNC1 = 1;
   localparam int SCG_BIT_SYNC0  = 4;
   localparam int SCG_BIT_TWOW0  = 12;
   localparam int SCG_BIT_CNT0   = 16;
   localparam int SCG_BIT_CNT1   = 17;
   localparam int SCG_BIT_CNT2   = 18;
   localparam int SCG_BIT_CMP0   = 24;
   localparam int SCG_BIT_CMP1   = 25;
   localparam int SCG_BIT_CMP2   = 26;
   typedef enum logic [1:0] {
      SCG_IDLE   = 2'b00,
      SCG_ACCESS = 2'b01,
      SCG_DONE   = 2'b11
   } scg_bus_e;
endpackage

/* logic/scg_gate_cell.sv */
// glitch-free clock gate for one peripheral
`timescale 1ns/1ps
module scg_gate_cell (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic en,
   output logic      gclk,
   output logic      en_q
);
   // enable latched while clock is low so gclk never chops a high phase
   logic en_lat;
   always_latch begin
      if (!ref_clk) begin
         en_lat = en;
      end
   end
   assign gclk = ref_clk & en_lat;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en;
      end
   end
endmodule

/* logic/scg_mode_sel.sv */
// per-peripheral choice of run, sleep or deep-sleep gate bit
`timescale 1ns/1ps
module scg_mode_sel import scg_pkg::*; (
   input  wire logic       run_bit,
   input  wire logic       sleep_bit,
   input  wire logic       deep_bit,
   input  wire logic       auto_gate,
   input  wire logic [1:0] pstate,
   output logic            en
);
   always_comb begin
      en = run_bit;
      if (auto_gate) begin
         if (pstate == SCG_PSTATE_SLEEP) begin
            en = sleep_bit;
         end else if (pstate == SCG_PSTATE_DEEP) begin
            en = deep_bit;
         end
      end
   end
endmodule

/* logic/scg_top.sv */
// sleep-mode clock gating control with apb registers and gated clocks
// Operation
// - a set gate bit clocks its peripheral, a clear one leaves it unclocked and disabled; comparator 2 has no clock or enable output.
// - any access to a peripheral whose clock is gated off ends in a bus fault; comparator 2 has no access input or fault flag.
// - reset clears every gate bit so all peripherals start unclocked.
// - sleep gate bits apply in sleep, run bits in running, deep-sleep bits in deep sleep.
// - sleep and deep-sleep bits only apply while the auto gating enable bit is set.
// - bits 26, 25, 24 enable analog comparators 2, 1, 0 (bit 26 only reaches the status word), read/write, reset zero.
// - bits 18, 17, 16 enable general-purpose counters 2, 1, 0, read/write, reset zero.
// - bit 12 enables two-wire serial module 0, read/write, reset zero.
// - bit 4 enables synchronous serial module 0, read/write, reset zero.
// - bits 1 and 0 enable asynchronous serial modules 1 and 0, read/write, reset zero.
// - reserved bits read zero and ignore writes; software keeps them on read-modify-write.
// - the sleep gating register is a 32-bit word at offset 0x114 of the system-control block.
`timescale 1ns/1ps
module scg_top import scg_pkg::*; (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [SCG_PADDR_W-1:0]    paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [1:0]                power_state,
   input  wire logic [SCG_NUM_PERIPH-1:0] periph_access,
   output logic      [SCG_NUM_PERIPH-1:0] periph_fault,
   output logic      [SCG_NUM_PERIPH-1:0] periph_en,
   output logic      [SCG_NUM_PERIPH-1:0] periph_gclk
);
   typedef struct packed {
      scg_bus_e                  bus;
      logic [31:0]               run_gate_reg;
      logic [31:0]               sleep_gate_reg;
      logic [31:0]               deep_gate_reg;
      logic [31:0]               run_cfg_reg;
      logic [31:0]               rdata;
      logic                      ready;
      logic                      slverr;
      logic [SCG_NUM_PERIPH-1:0] fault;
   } scg_state_s;

   scg_state_s st_reg;
   scg_state_s st_next;

   localparam int SCG_BITMAP [SCG_NUM_PERIPH] = '{SCG_BIT_ASYNC0, SCG_BIT_ASYNC1, SCG_BIT_SYNC0,
                                                 SCG_BIT_TWOW0, SCG_BIT_CNT0, SCG_BIT_CNT1,
                                                 SCG_BIT_CNT2, SCG_BIT_CMP0, SCG_BIT_CMP1};

   logic [SCG_NUM_PERIPH-1:0] eff_en;
   logic [SCG_NUM_PERIPH-1:0] en_q;
   logic [31:0]               wmask;
   logic                      auto_gate;

   assign auto_gate = st_reg.run_cfg_reg[SCG_AUTO_GATE_BIT];

   // one selector and one gate per peripheral (comparator 2 handled below)
   genvar gi;
   generate
      for (gi = 0; gi < SCG_NUM_PERIPH; gi++) begin : g_periph
         scg_mode_sel u_sel (
            .run_bit   (st_reg.run_gate_reg[SCG_BITMAP[gi]]),
            .sleep_bit (st_reg.sleep_gate_reg[SCG_BITMAP[gi]]),
            .deep_bit  (st_reg.deep_gate_reg[SCG_BITMAP[gi]]),
            .auto_gate (auto_gate),
            .pstate    (power_state),
            .en        (eff_en[gi])
         );
         scg_gate_cell u_gate (
            .ref_clk (ref_clk),
            .rst     (rst),
            .en      (eff_en[gi]),
            .gclk    (periph_gclk[gi]),
            .en_q    (en_q[gi])
         );
      end
   endgenerate

   // comparator 2 has only an enable level, no own gated clock port
   logic cmp2_en;
   scg_mode_sel u_sel_cmp2 (
      .run_bit   (st_reg.run_gate_reg[SCG_BIT_CMP2]),
      .sleep_bit (st_reg.sleep_gate_reg[SCG_BIT_CMP2]),
      .deep_bit  (st_reg.deep_gate_reg[SCG_BIT_CMP2]),
      .auto_gate (auto_gate),
      .pstate    (power_state),
      .en        (cmp2_en)
   );

   always_comb begin
      wmask = 32'h00000000;
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = pstrb[b] ? 8'hFF : 8'h00;
      end
   end

   always_comb begin
      st_next       = st_reg;
      st_next.ready = 1'b0;
      st_next.slverr = 1'b0;
      // access to an unclocked unit faults; held one cycle after request
      st_next.fault = periph_access & ~en_q;
      case (st_reg.bus)
         SCG_IDLE: begin
            if (psel && !penable) begin
               st_next.bus = SCG_ACCESS;
            end
         end
         SCG_ACCESS: begin
            if (psel && penable) begin
               st_next.ready = 1'b1;
               st_next.bus   = SCG_DONE;
               st_next.rdata = SCG_ZERO_WORD;
               case (paddr)
                  SCG_SLEEP_GATE_OFF: begin
                     if (pwrite) begin
                        // reserved bits never stored
                        st_next.sleep_gate_reg = ((st_reg.sleep_gate_reg & ~wmask) |
                                                  (pwdata & wmask)) & SCG_GATE_MASK;
                     end else begin
                        st_next.rdata = st_reg.sleep_gate_reg;
                     end
                  end
                  SCG_RUN_GATE_OFF: begin
                     if (pwrite) begin
                        st_next.run_gate_reg = ((st_reg.run_gate_reg & ~wmask) |
                                                (pwdata & wmask)) & SCG_GATE_MASK;
                     end else begin
                        st_next.rdata = st_reg.run_gate_reg;
                     end
                  end
                  SCG_DEEP_GATE_OFF: begin
                     if (pwrite) begin
                        st_next.deep_gate_reg = ((st_reg.deep_gate_reg & ~wmask) |
                                                 (pwdata & wmask)) & SCG_GATE_MASK;
                     end else begin
                        st_next.rdata = st_reg.deep_gate_reg;
                     end
                  end
                  SCG_RUN_CFG_OFF: begin
                     if (pwrite) begin
                        st_next.run_cfg_reg = ((st_reg.run_cfg_reg & ~wmask) |
                                               (pwdata & wmask)) & SCG_RUN_CFG_MASK;
                     end else begin
                        st_next.rdata = st_reg.run_cfg_reg;
                     end
                  end
                  SCG_POWER_STATE_OFF: begin
                     // read-only view of the effective enables
                     if (pwrite) begin
                        st_next.slverr = 1'b1;
                     end else begin
                        st_next.rdata[SCG_NUM_PERIPH:0] = {cmp2_en, eff_en};
                     end
                  end
                  default: begin
                     st_next.slverr = 1'b1;
                  end
               endcase
            end else begin
               st_next.bus = SCG_IDLE;
            end
         end
         SCG_DONE: begin
            // one idle cycle keeps each transfer exactly two-phase plus wait
            st_next.bus = SCG_IDLE;
         end
         default: begin
            st_next.bus = SCG_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_reg.bus            <= SCG_IDLE;
         st_reg.run_gate_reg   <= SCG_GATE_RESET;
         st_reg.sleep_gate_reg <= SCG_GATE_RESET;
         st_reg.deep_gate_reg  <= SCG_GATE_RESET;
         st_reg.run_cfg_reg    <= SCG_RUN_CFG_RESET;
         st_reg.rdata          <= SCG_ZERO_WORD;
         st_reg.ready          <= 1'b0;
         st_reg.slverr         <= 1'b0;
         st_reg.fault          <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata       = st_reg.rdata;
   assign pready       = st_reg.ready;
   assign pslverr      = st_reg.slverr;
   assign periph_fault = st_reg.fault;
   assign periph_en    = en_q;
endmodule

/* dv/scg_top_props.sv */
// assertions on the ports of the sleep-mode clock gating block
`timescale 1ns/1ps
module scg_top_props import scg_pkg::*; (
   input wire logic                      ref_clk,
   input wire logic                      rst,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [SCG_PADDR_W-1:0]    paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [3:0]                pstrb,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic [1:0]                power_state,
   input wire logic [SCG_NUM_PERIPH-1:0] periph_access,
   input wire logic [SCG_NUM_PERIPH-1:0] periph_fault,
   input wire logic [SCG_NUM_PERIPH-1:0] periph_en,
   input wire logic [SCG_NUM_PERIPH-1:0] periph_gclk
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_fault_gated: assert property (1 |=> periph_fault == $past(periph_access & ~periph_en))
      else $error("fault flag does not follow gated access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_ready_after: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late after access");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_err_data: assert property (pslverr |-> prdata == SCG_ZERO_WORD)
      else $error("read data on error not zero");
   chk_idle_ready: assert property (!psel |=> !pready)
      else $error("pready without select");
   chk_setup_ready: assert property (psel && !penable |=> !pready)
      else $error("pready in setup");
   chk_en_stable: assert property (($stable(power_state) && !psel) [*3] |-> $stable(periph_en))
      else $error("enables moved with no cause");
endmodule
bind scg_top scg_top_props scg_top_props_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .power_state(power_state), .periph_access(periph_access), .periph_fault(periph_fault),
   .periph_en(periph_en), .periph_gclk(periph_gclk));

/* dv/scg_top_tb_top.sv */
// self-checking bench for the sleep-mode clock gating block
`timescale 1ns/1ps
module scg_top_tb_top import scg_pkg::*; ;
   logic                      ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [SCG_PADDR_W-1:0]    paddr;
   logic [31:0]               pwdata, prdata, rd, w;
   logic [3:0]                pstrb;
   logic [1:0]                power_state;
   logic [SCG_NUM_PERIPH-1:0] periph_access, periph_fault, periph_en, periph_gclk;
   int                        fail_count, tests_run, cyc;
   int                        bits[10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
   logic [1:0]                pst[3] = '{2'h0, 2'h1, 2'h3};
   scg_top scg_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_state(power_state), .periph_access(periph_access), .periph_fault(periph_fault),
      .periph_en(periph_en), .periph_gclk(periph_gclk));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one idle cycle always precedes the setup, as the slave needs
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1); // only the bench timeout ends a hung wait
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [9:0] to_idx(input logic [31:0] v);
      return {v[26], v[25], v[24], v[18], v[17], v[16], v[12], v[4], v[1], v[0]};
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      power_state = 2'h0;
      periph_access = 9'h000;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("sleep_reset", 32'h00000000, rd);
      check("en_reset", 32'h0, {23'h0, periph_en});
      foreach (bits[i]) begin
         apb(1'b1, SCG_SLEEP_GATE_OFF, 32'h1 << bits[i]);
         apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
         check("field", 32'h1 << bits[i], rd);
      end
      apb(1'b1, SCG_SLEEP_GATE_OFF, ~32'h07071013);
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("reserved", 32'h00000000, rd);
      apb(1'b1, SCG_SLEEP_GATE_OFF, 32'hFFFFFFFF);
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("all_bits", 32'h07071013, rd);
      $display("register test done");
      apb(1'b1, SCG_RUN_GATE_OFF, 32'h00050011);
      apb(1'b1, SCG_DEEP_GATE_OFF, 32'h02001002);
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, SCG_RUN_CFG_OFF, j ? SCG_RUN_CFG_MASK : 32'h0);
         foreach (pst[k]) begin
            power_state <= pst[k];
            w = (j && k == 1) ? 32'h07071013 : (j && k == 2) ? 32'h02001002 : 32'h00050011;
            apb(1'b0, SCG_POWER_STATE_OFF, 32'h0);
            check("status", {22'h0, to_idx(w)}, rd);
            check("enables", {22'h0, to_idx(w)} & 32'h000001FF, {23'h0, periph_en});
            #1;
            check("gclk", {22'h0, to_idx(w)} & 32'h000001FF, {23'h0, periph_gclk});
            @(posedge ref_clk);
         end
      end
      $display("mode test done");
      periph_access <= 9'h1FF;
      repeat (2) @(posedge ref_clk);
      check("fault", ~{22'h0, to_idx(32'h02001002)} & 32'h000001FF, {23'h0, periph_fault});
      periph_access <= 9'h000;
      apb(1'b0, 12'h300, 32'h0);
      check("unmapped_err", 32'h1, {31'h0, err});
      apb(1'b1, SCG_POWER_STATE_OFF, 32'hFFFFFFFF);
      check("ro_err", 32'h1, {31'h0, err});
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("kept", 32'h07071013, rd);
      pstrb <= 4'h4;
      apb(1'b1, SCG_SLEEP_GATE_OFF, 32'h00000000);
      pstrb <= 4'hF;
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("byte_lane", 32'h07001013, rd);
      $display("fault test done");
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, SCG_SLEEP_GATE_OFF, 32'h0);
      check("mid_reset", 32'h00000000, rd);
      check("mid_reset_en", 32'h0, {23'h0, periph_en});
      $display("reset test done");
      complete_run();
   end
endmodule
